//--- hdl/spc_regs.vh
// Purpose: Offsets, field positions and reset values of the servo pin and control registers.
// Assumes: Byte offsets in configuration space, one aligned 32-bit word per register.
// Notes:   Definitions only.
`ifndef SPC_REGS_VH
`define SPC_REGS_VH

// ==========================================================================
// Register offsets
`define SPC_PIN_SELECT_OFFSET 8'hc8
`define SPC_CONTROL_OFFSET 8'hd0

// ==========================================================================
// Reset values
`define SPC_PIN_SELECT_RESET 32'h0000_0000
`define SPC_CONTROL_RESET 32'h0000_0000

// ==========================================================================
// Control register fields
`define SPC_TIMEBASE_BIT 24
`define SPC_DECODE_ON_BIT 23
`define SPC_ROUTE_MSB 19
`define SPC_ROUTE_LSB 16
`define SPC_BASE_MSB 15
`define SPC_BASE_LSB 9

// ==========================================================================
// Pin select byte positions per port group
`define SPC_GROUP_ZERO_LSB 0
`define SPC_GROUP_ONE_LSB 8
`define SPC_GROUP_TWO_LSB 16
`define SPC_GROUP_FOUR_LSB 24

// ==========================================================================
// Interrupt routing codes
`define SPC_ROUTE_NONE 4'h0
`define SPC_ROUTE_LINE9 4'h1
`define SPC_ROUTE_LINE3 4'h2
`define SPC_ROUTE_LINE10 4'h3
`define SPC_ROUTE_LINE4 4'h4
`define SPC_ROUTE_LINE5 4'h5
`define SPC_ROUTE_LINE7 4'h6
`define SPC_ROUTE_LINE6 4'h7
`define SPC_ROUTE_LINE1 4'h8
`define SPC_ROUTE_LINE11 4'h9
`define SPC_ROUTE_LINE12 4'hb
`define SPC_ROUTE_LINE14 4'hd
`define SPC_ROUTE_LINE15 4'hf

`endif

//--- hdl/spc_irq_route.v
// Purpose: Decodes the servo interrupt routing code onto one legacy request line.
// Assumes: Pure combinational; the caller registers the result.
// Notes:   Reserved codes and code zero drive no line.
`timescale 1ns/1ps
`include "spc_regs.vh"

module spc_irq_route (
    input wire [3:0] route_code,
    input wire servo_irq,
    output reg [15:0] irq_lines
);

    // ======================================================================
    // Routing table
    always @* begin
        irq_lines = 16'h0000;
        case (route_code)
            `SPC_ROUTE_LINE9: irq_lines[9] = servo_irq; // [R10] [R11]
            `SPC_ROUTE_LINE3: irq_lines[3] = servo_irq; // [R10]
            `SPC_ROUTE_LINE10: irq_lines[10] = servo_irq; // [R10]
            `SPC_ROUTE_LINE4: irq_lines[4] = servo_irq; // [R10]
            `SPC_ROUTE_LINE5: irq_lines[5] = servo_irq; // [R10]
            `SPC_ROUTE_LINE7: irq_lines[7] = servo_irq; // [R10]
            `SPC_ROUTE_LINE6: irq_lines[6] = servo_irq; // [R10]
            `SPC_ROUTE_LINE1: irq_lines[1] = servo_irq; // [R10]
            `SPC_ROUTE_LINE11: irq_lines[11] = servo_irq; // [R10]
            `SPC_ROUTE_LINE12: irq_lines[12] = servo_irq; // [R10]
            `SPC_ROUTE_LINE14: irq_lines[14] = servo_irq; // [R10]
            `SPC_ROUTE_LINE15: irq_lines[15] = servo_irq; // [R10]
            default: irq_lines = 16'h0000; // [R12]
        endcase
    end

endmodule // spc_irq_route

//--- hdl/spc_top.v
// Purpose: Servo pin selection, timebase, I/O window decode and interrupt routing registers.
// Assumes: Configuration accesses and pin-option levels come from logic on clk.
// Notes:   Read data appears one cycle after the read strobe.
`timescale 1ns/1ps
`include "spc_regs.vh"

// Behaviour
// R1 - Top select byte steers port-four pins: 0 port I/O, 1 servo 24..31.
// R2 - Port-four servo byte acts only while south bridge pin option bit is one.
// R3 - Pin option one gives shared pins to port four, zero to serial port.
// R4 - Third select byte steers port-two pins: 0 port I/O, 1 servo 16..23.
// R5 - Port-two servo byte acts only while board option latch bit is one.
// R6 - Second select byte steers port-one pins: 0 port I/O, 1 servo 8..15.
// R7 - Lowest select byte steers port-zero pins: 0 port I/O, 1 servo 0..7.
// R8 - Control bit 24 chooses servo timebase: 0 10 MHz, 1 50 MHz.
// R9 - Control bit 23 enables servo I/O window decode; zero ignores I/O cycles.
// R10 - Four-bit route code drives one legacy request line per the table.
// R11 - Routing can direct servo interrupt to any listed legacy line.
// R12 - Firmware must not program reserved route codes 1010, 1100, 1110.
// R13 - Control bits 15..9 hold the servo I/O base address bits, read/write.
// R14 - Control bits 8..0 read zero; writes to them are discarded.
// R15 - Decode claims I/O cycles whose address bits 15..9 match the base.
// R16 - With gating false, group pins keep their non-servo function.
module spc_top #(
    parameter GROUP_WIDTH = 8
) (
    input wire clk,
    input wire rst,
    input wire [7:0] cfg_addr,
    input wire cfg_wr,
    input wire cfg_rd,
    input wire [3:0] cfg_be,
    input wire [31:0] cfg_wdata,
    output reg [31:0] cfg_rdata,
    output reg cfg_rvalid,
    input wire serial_or_port_four_choice,
    input wire board_option_latch_bit,
    input wire [4*GROUP_WIDTH-1:0] general_io_out,
    input wire [4*GROUP_WIDTH-1:0] servo_out,
    input wire [GROUP_WIDTH-1:0] serial_pin_out,
    output reg [4*GROUP_WIDTH-1:0] pin_out,
    output reg [4*GROUP_WIDTH-1:0] pin_is_servo,
    output reg servo_timebase_select,
    input wire io_cycle,
    input wire [15:0] io_addr,
    output reg servo_io_claim,
    input wire servo_irq,
    output reg [15:0] legacy_irq
);

    localparam NGRP = 4;

    // ======================================================================
    // Register storage
    reg [31:0] port_servo_pin_choice;
    reg servo_io_decode_on;
    reg [3:0] servo_interrupt_route_code;
    reg [6:0] servo_io_window_base;
    reg [31:0] servo_unit_control;

    wire sel_hit = (cfg_addr == `SPC_PIN_SELECT_OFFSET);
    wire ctl_hit = (cfg_addr == `SPC_CONTROL_OFFSET);

    // Timebase register doubles as the output flop
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            port_servo_pin_choice <= `SPC_PIN_SELECT_RESET;
            servo_timebase_select <= 1'b0;
            servo_io_decode_on <= 1'b0;
            servo_interrupt_route_code <= 4'h0;
            servo_io_window_base <= 7'h00;
        end else if (cfg_wr) begin
            if (sel_hit) begin
                if (cfg_be[0])
                    port_servo_pin_choice[7:0] <= cfg_wdata[7:0]; // [R7]
                if (cfg_be[1])
                    port_servo_pin_choice[15:8] <= cfg_wdata[15:8]; // [R6]
                if (cfg_be[2])
                    port_servo_pin_choice[23:16] <= cfg_wdata[23:16]; // [R4]
                if (cfg_be[3])
                    port_servo_pin_choice[31:24] <= cfg_wdata[31:24]; // [R1]
            end
            if (ctl_hit) begin
                if (cfg_be[3])
                    servo_timebase_select <= cfg_wdata[`SPC_TIMEBASE_BIT]; // [R8]
                if (cfg_be[2]) begin
                    servo_io_decode_on <= cfg_wdata[`SPC_DECODE_ON_BIT]; // [R9]
                    servo_interrupt_route_code <=
                        cfg_wdata[`SPC_ROUTE_MSB:`SPC_ROUTE_LSB]; // [R10]
                end
                if (cfg_be[1])
                    servo_io_window_base <= cfg_wdata[`SPC_BASE_MSB:`SPC_BASE_LSB]; // [R13]
            end
        end
    end

    // Reserved and low bits always assemble as zero
    always @* begin
        servo_unit_control = `SPC_CONTROL_RESET; // [R14]
        servo_unit_control[`SPC_TIMEBASE_BIT] = servo_timebase_select;
        servo_unit_control[`SPC_DECODE_ON_BIT] = servo_io_decode_on;
        servo_unit_control[`SPC_ROUTE_MSB:`SPC_ROUTE_LSB] = servo_interrupt_route_code;
        servo_unit_control[`SPC_BASE_MSB:`SPC_BASE_LSB] = servo_io_window_base; // [R13]
    end

    // ======================================================================
    // Read path; unmapped offsets return zero
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_rdata <= 32'h0000_0000;
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rvalid <= cfg_rd;
            if (cfg_rd) begin
                if (sel_hit)
                    cfg_rdata <= port_servo_pin_choice;
                else if (ctl_hit)
                    cfg_rdata <= servo_unit_control; // [R14]
                else
                    cfg_rdata <= 32'h0000_0000;
            end
        end
    end

    // ======================================================================
    // Pin multiplexing per port group
    wire [NGRP-1:0] group_gate;
    assign group_gate[0] = 1'b1; // [R7]
    assign group_gate[1] = 1'b1; // [R6]
    assign group_gate[2] = board_option_latch_bit; // [R5]
    assign group_gate[3] = serial_or_port_four_choice; // [R2]

    wire [4*GROUP_WIDTH-1:0] next_pin_out;
    wire [4*GROUP_WIDTH-1:0] next_pin_is_servo;

    genvar g;
    generate
        for (g = 0; g < NGRP; g = g + 1) begin : grp
            wire [GROUP_WIDTH-1:0] sel;
            wire [GROUP_WIDTH-1:0] plain;
            // Stored choice is masked while the group's gate is low
            assign sel = port_servo_pin_choice[g*GROUP_WIDTH +: GROUP_WIDTH]
                & {GROUP_WIDTH{group_gate[g]}}; // [R16]
            if (g == NGRP - 1) begin : shared
                // Shared pins fall back to the serial port when the option is zero
                assign plain = serial_or_port_four_choice
                    ? general_io_out[g*GROUP_WIDTH +: GROUP_WIDTH]
                    : serial_pin_out; // [R3]
            end else begin : own
                assign plain = general_io_out[g*GROUP_WIDTH +: GROUP_WIDTH];
            end
            assign next_pin_is_servo[g*GROUP_WIDTH +: GROUP_WIDTH] = sel;
            assign next_pin_out[g*GROUP_WIDTH +: GROUP_WIDTH] =
                (servo_out[g*GROUP_WIDTH +: GROUP_WIDTH] & sel)
                | (plain & ~sel); // [R1] [R4] [R6] [R7]
        end
    endgenerate

    // ======================================================================
    // Interrupt routing
    wire [15:0] next_legacy_irq;

    spc_irq_route u_route (
        .route_code(servo_interrupt_route_code),
        .servo_irq(servo_irq),
        .irq_lines(next_legacy_irq)
    );

    // ======================================================================
    // Output flops
    wire next_servo_io_claim = servo_io_decode_on & io_cycle
        & (io_addr[15:9] == servo_io_window_base); // [R9] [R15]

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_out <= {4*GROUP_WIDTH{1'b0}};
            pin_is_servo <= {4*GROUP_WIDTH{1'b0}};
            servo_io_claim <= 1'b0;
            legacy_irq <= 16'h0000;
        end else begin
            pin_out <= next_pin_out;
            pin_is_servo <= next_pin_is_servo; // [R16]
            servo_io_claim <= next_servo_io_claim;
            legacy_irq <= next_legacy_irq; // [R11]
        end
    end

endmodule // spc_top

//--- verification/spc_chk.sv
// Purpose: Port-level checks of the servo pin and control register block.
// Assumes: One clock domain; shadow copies follow configuration writes.
// Notes:   Bound to spc_top.
`timescale 1ns/1ps
`include "spc_regs.vh"
module spc_chk #(
    parameter GROUP_WIDTH = 8
) (
    input wire clk,
    input wire rst,
    input wire cfg_wr,
    input wire cfg_rd,
    input wire cfg_rvalid,
    input wire serial_or_port_four_choice,
    input wire board_option_latch_bit,
    input wire servo_timebase_select,
    input wire io_cycle,
    input wire servo_io_claim,
    input wire servo_irq,
    input wire [7:0] cfg_addr,
    input wire [3:0] cfg_be,
    input wire [31:0] cfg_wdata,
    input wire [31:0] cfg_rdata,
    input wire [GROUP_WIDTH-1:0] serial_pin_out,
    input wire [4*GROUP_WIDTH-1:0] pin_out,
    input wire [4*GROUP_WIDTH-1:0] pin_is_servo,
    input wire [15:0] io_addr,
    input wire [15:0] legacy_irq
);
// ==========================================================================
// Shadow registers
reg [31:0] sel;
reg tb, en;
reg [3:0] rt;
reg [6:0] base;
wire [31:0] m = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};
wire [31:0] ctl = {7'h0, tb, en, 3'h0, rt, base, 9'h0};
wire claim_exp = en & io_cycle & (io_addr[15:9] == base);
always @(posedge clk or posedge rst) begin
    if (rst) begin
        sel <= 32'h0;
        {tb, en, rt, base} <= 13'h0;
    end else if (cfg_wr && cfg_addr == `SPC_PIN_SELECT_OFFSET) begin
        sel <= (sel & ~m) | (cfg_wdata & m);
    end else if (cfg_wr && cfg_addr == `SPC_CONTROL_OFFSET) begin
        if (cfg_be[3]) tb <= cfg_wdata[24];
        if (cfg_be[2]) {en, rt} <= {cfg_wdata[23], cfg_wdata[19:16]};
        if (cfg_be[1]) base <= cfg_wdata[15:9];
    end
end
// ==========================================================================
// Assertions
default clocking @(posedge clk); endclocking
default disable iff (rst);
sequence s_ctl_read; cfg_rd && cfg_addr == `SPC_CONTROL_OFFSET; endsequence
sequence s_sel_read; cfg_rd && cfg_addr == `SPC_PIN_SELECT_OFFSET; endsequence
sequence s_irq_to_nine; servo_irq && rt == `SPC_ROUTE_LINE9; endsequence
a_ctl_read_value: assert property (s_ctl_read |=> cfg_rvalid && cfg_rdata == $past(ctl))
    else $error("control read value wrong");
a_sel_read_value: assert property (s_sel_read |=> cfg_rvalid && cfg_rdata == $past(sel))
    else $error("pin select read value wrong");
a_timebase_level: assert property (servo_timebase_select == tb)
    else $error("timebase select wrong");
a_claim_match: assert property (1'b1 |=> servo_io_claim == $past(claim_exp))
    else $error("io claim wrong");
a_low_groups: assert property (1'b1 |=> pin_is_servo[15:0] == $past(sel[15:0]))
    else $error("groups zero and one selection wrong");
a_group_two_gate: assert property (!board_option_latch_bit |=> pin_is_servo[23:16] == 8'h0)
    else $error("group two not gated");
a_group_four_gate: assert property (!serial_or_port_four_choice |=> pin_is_servo[31:24] == 8'h0
    && pin_out[31:24] == $past(serial_pin_out))
    else $error("group four not serial");
a_route_idle: assert property (!servo_irq |=> legacy_irq == 16'h0)
    else $error("legacy line raised without interrupt");
a_route_nine: assert property (s_irq_to_nine |=> legacy_irq == 16'h0200)
    else $error("route to line nine wrong");
endmodule // spc_chk
bind spc_top spc_chk #(.GROUP_WIDTH(GROUP_WIDTH)) u_chk (.clk, .rst, .cfg_wr, .cfg_rd,
    .cfg_rvalid, .serial_or_port_four_choice, .board_option_latch_bit, .servo_timebase_select,
    .io_cycle, .servo_io_claim, .servo_irq, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata,
    .serial_pin_out, .pin_out, .pin_is_servo, .io_addr, .legacy_irq);

//--- verification/test_servo_pin_and_control_config.sv
// Purpose: Directed register, pin mux, decode and routing tests.
// Assumes: Inputs change at the falling edge.
// Notes:   Reserved routing codes are never programmed.
`timescale 1ns/1ps
`include "spc_regs.vh"
module test_servo_pin_and_control_config;
reg clk = 1'b0, rst = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0, p4 = 1'b0, p2 = 1'b0;
reg io_cycle = 1'b0, servo_irq = 1'b0;
reg [7:0] cfg_addr = 8'h0, ser = 8'h81;
reg [3:0] cfg_be = 4'h0, nib;
reg [31:0] cfg_wdata = 32'h0, gen = 32'h1234_5678, srv = 32'hedcb_a987, s, ex;
reg [15:0] io_addr = 16'h0;
wire [31:0] cfg_rdata, pin_out, pin_is_servo;
wire cfg_rvalid, tbase, claim;
wire [15:0] legacy_irq;
integer errors = 0, cmp_count = 0, k;
always #50 clk = ~clk;
spc_top #(.GROUP_WIDTH(8)) u_dut (.clk(clk), .rst(rst), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .serial_or_port_four_choice(p4), .board_option_latch_bit(p2),
    .general_io_out(gen), .servo_out(srv), .serial_pin_out(ser), .pin_out(pin_out),
    .pin_is_servo(pin_is_servo), .servo_timebase_select(tbase), .io_cycle(io_cycle),
    .io_addr(io_addr), .servo_io_claim(claim), .servo_irq(servo_irq), .legacy_irq(legacy_irq));
// ==========================================================================
// Tasks
task print_verdict;
begin
    $display("Comparisons %0d, errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
end
endtask
task chk(input string nm, input [31:0] e, input [31:0] g);
begin
    cmp_count = cmp_count + 1;
    if (g !== e) begin
        errors = errors + 1;
        $display("Error %s expected %h seen %h", nm, e, g);
    end
end
endtask
task wr(input [7:0] a, input [3:0] be, input [31:0] d);
begin
    @(negedge clk);
    {cfg_addr, cfg_be, cfg_wdata, cfg_wr} = {a, be, d, 1'b1};
    @(negedge clk);
    cfg_wr = 1'b0;
end
endtask
task rd(input [7:0] a, input [31:0] e);
integer n;
begin
    @(negedge clk);
    {cfg_addr, cfg_rd} = {a, 1'b1};
    @(negedge clk);
    cfg_rd = 1'b0;
    for (n = 0; n < 4 && cfg_rvalid !== 1'b1; n = n + 1) @(negedge clk);
    if (n == 4) begin
        errors = errors + 1;
        print_verdict;
    end
    chk("cfg_rdata", e, cfg_rdata);
end
endtask
// ==========================================================================
// Sequence
initial begin
    repeat (6) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    rd(`SPC_PIN_SELECT_OFFSET, 32'h0);
    rd(`SPC_CONTROL_OFFSET, 32'h0);
    chk("timebase", 32'h0, {31'h0, tbase});
    wr(`SPC_CONTROL_OFFSET, 4'hf, 32'hffff_ffff);
    rd(`SPC_CONTROL_OFFSET, 32'h018f_fe00);
    wr(`SPC_CONTROL_OFFSET, 4'hf, 32'h0180_8bff);
    rd(`SPC_CONTROL_OFFSET, 32'h0180_8a00);
    chk("timebase", 32'h1, {31'h0, tbase});
    for (k = 0; k < 5; k = k + 1) begin
        if (k == 4) wr(`SPC_CONTROL_OFFSET, 4'h4, 32'h0);
        io_addr = k[0] ? 16'h8c00 : (k[1] ? 16'h8bff : 16'h8a00);
        @(negedge clk) io_cycle = 1'b1;
        @(negedge clk) io_cycle = 1'b0;
        chk("servo_io_claim", (k == 0 || k == 2), {31'h0, claim});
    end
    wr(`SPC_PIN_SELECT_OFFSET, 4'hf, 32'ha5c3_3c5a);
    wr(`SPC_PIN_SELECT_OFFSET, 4'h2, 32'hffff_ffff);
    rd(`SPC_PIN_SELECT_OFFSET, 32'ha5c3_ff5a);
    for (k = 0; k < 4; k = k + 1) begin
        {p2, p4} = k[1:0];
        repeat (2) @(negedge clk);
        s = 32'ha5c3_ff5a & {{8{p4}}, {8{p2}}, 16'hffff};
        ex = (s & srv) | (~s & gen);
        if (!p4) ex[31:24] = ser;
        chk("pin_is_servo", s, pin_is_servo);
        chk("pin_out", ex, pin_out);
    end
    servo_irq = 1'b1;
    for (k = 0; k < 16; k = k + 1) begin
        nib = 64'hf0e0_c0b1_6754_a390 >> (4 * k);
        if (nib != 4'h0 || k == 0) begin
            wr(`SPC_CONTROL_OFFSET, 4'h4, k << 16);
            repeat (2) @(negedge clk);
            chk("legacy_irq", (nib == 4'h0) ? 32'h0 : 32'h1 << nib, legacy_irq);
        end
    end
    servo_irq = 1'b0;
    repeat (2) @(negedge clk);
    chk("legacy_irq", 32'h0, legacy_irq);
    print_verdict;
end
endmodule // test_servo_pin_and_control_config
